/* verilog/iospm_defines.svh */
// register offsets, field positions and function codes for the slot process map
`ifndef IOSPM_DEFINES_SVH
`define IOSPM_DEFINES_SVH

`define IOSPM_WORDS_PER_SLOT 4'ha
`define IOSPM_WORD_STATUS 4'h0
`define IOSPM_WORD_RSVD 4'h1
`define IOSPM_WORD_CH1 4'h2
`define IOSPM_WORD_CH4 4'h5
`define IOSPM_STALE_BIT 8
`define IOSPM_TYPE_MSB 7
`define IOSPM_TYPE_NONE 8'h00
`define IOSPM_SLOT_ADDR_MAX 7'h63
`define IOSPM_RADIO_MASTER 8'h01
`define IOSPM_RANGE_INPUT 3'h3
`define IOSPM_RANGE_HOLDING 3'h4
`define IOSPM_FC_READ_HOLDING 8'h03
`define IOSPM_FC_READ_INPUT 8'h04
`define IOSPM_FC_WRITE_MULTIPLE 8'h10

`endif

/* verilog/iospm_pkg.sv */
// types shared by the slot process map
package iospm_pkg;
    typedef logic [15:0] iospm_word_type;
    typedef enum logic [2:0] {
        IOSPM_IDLE = 3'b001,
        IOSPM_READ = 3'b010,
        IOSPM_WRITE = 3'b100
    } iospm_state_type;
endpackage

/* verilog/iospm_addr_decode.sv */
// splits a decimal register number into range digit, slot address and word index
`timescale 1ns/1ps
`default_nettype none
`include "iospm_defines.svh"
module iospm_addr_decode (
    // register number as five decimal digits, e.g. 30012
    input wire logic [16:0] reg_num_i,
    // the slot's selector switch setting
    input wire logic [6:0] slot_addr_i,
    // decoded fields
    output logic [2:0] range_o,
    output logic hit_o,
    output logic [3:0] word_o
);
    logic [16:0] below_range;
    logic [16:0] slot_part;
    always_comb begin
        range_o = 3'(reg_num_i / 17'd10000);
        below_range = reg_num_i % 17'd10000;
        slot_part = below_range / 17'd10;
        word_o = 4'(below_range % 17'd10);
        hit_o = (slot_part == {10'h000, slot_addr_i});
    end
endmodule
`default_nettype wire

/* verilog/iospm_map.sv */
// process map for a temperature input slot and an analog output slot
`timescale 1ns/1ps
`default_nettype none
`include "iospm_defines.svh"
// Overview of operation
// - temperature slot: six input registers from base, read with function four
// - output slot: six holding registers, read function three, written function sixteen
// - middle two decimal digits of register number come from slot switch
// - bit eight of each status word is the staleness flag
// - on input link failure set flag and freeze temperature words
// - module type field reads zero when slot type invalid
// - any master write to output slot clears its staleness flag
// - output flag stays clear until next reset
// - analog outputs one to four taken from words two to five
// - map lives in master radio unit, station one
module iospm_map #(
    parameter logic [7:0] TEMP_TYPE_ID = 8'h5a, // arbitrary identity value
    parameter logic [7:0] OUT_TYPE_ID = 8'h6b // arbitrary identity value
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // own radio station number
    input wire logic [7:0] radio_station_number_i,
    // slot switch settings, decimal 0 to 99
    input wire logic [6:0] temp_slot_addr_i,
    input wire logic [6:0] out_slot_addr_i,
    // temperature slot side
    input wire logic temp_link_ok_i,
    input wire logic temp_type_valid_i,
    input wire logic temp_update_i,
    input wire logic [15:0] temperature_value_one_i,
    input wire logic [15:0] temperature_value_two_i,
    input wire logic [15:0] temperature_value_three_i,
    input wire logic [15:0] temperature_value_four_i,
    // output slot side
    input wire logic out_type_valid_i,
    output logic [15:0] analog_out_value_one_o,
    output logic [15:0] analog_out_value_two_o,
    output logic [15:0] analog_out_value_three_o,
    output logic [15:0] analog_out_value_four_o,
    // register request from the bus master
    input wire logic req_valid_i,
    input wire logic [7:0] req_func_i,
    input wire logic [16:0] req_reg_i,
    input wire logic [15:0] req_wdata_i,
    // register answer
    output logic rsp_valid_o,
    output logic rsp_ok_o,
    output logic [15:0] rsp_rdata_o
);
    typedef struct packed {
        iospm_pkg::iospm_word_type [3:0] temp;
        iospm_pkg::iospm_word_type [3:0] aout;
        logic temp_stale;
        logic out_stale;
        logic rsp_valid;
        logic rsp_ok;
        iospm_pkg::iospm_word_type rdata;
    } iospm_state_type;

    iospm_state_type state_reg;
    iospm_state_type state_next;
    logic [2:0] range;
    logic slot_hit_in;
    logic slot_hit_out;
    logic [3:0] word_in;
    logic [3:0] word_out;
    logic [2:0] range_out;
    logic [1:0] chan_in;
    logic [1:0] chan_out;
    logic ch_in;
    logic ch_out;
    logic for_me;
    logic is_read_in;
    logic is_read_hold;
    logic is_write_hold;
    logic slot_ok_in;
    logic slot_ok_out;
    iospm_pkg::iospm_state_type op;
    iospm_pkg::iospm_word_type in_status;
    iospm_pkg::iospm_word_type out_status;
    iospm_pkg::iospm_word_type in_word;
    iospm_pkg::iospm_word_type out_word;

    iospm_addr_decode u_dec_in (
        .reg_num_i(req_reg_i),
        .slot_addr_i(temp_slot_addr_i),
        .range_o(range),
        .hit_o(slot_hit_in),
        .word_o(word_in)
    );

    iospm_addr_decode u_dec_out (
        .reg_num_i(req_reg_i),
        .slot_addr_i(out_slot_addr_i),
        .range_o(range_out),
        .hit_o(slot_hit_out),
        .word_o(word_out)
    );

    always_comb begin
        for_me = (radio_station_number_i == `IOSPM_RADIO_MASTER);
        // switch settings above 99 address no slot at all
        slot_ok_in = slot_hit_in && (temp_slot_addr_i <= `IOSPM_SLOT_ADDR_MAX);
        slot_ok_out = slot_hit_out && (out_slot_addr_i <= `IOSPM_SLOT_ADDR_MAX);
        is_read_in = for_me && (req_func_i == `IOSPM_FC_READ_INPUT)
            && (range == `IOSPM_RANGE_INPUT) && slot_ok_in;
        // holding range, functions three and sixteen
        is_read_hold = for_me && (req_func_i == `IOSPM_FC_READ_HOLDING)
            && (range_out == `IOSPM_RANGE_HOLDING) && slot_ok_out;
        is_write_hold = for_me && (req_func_i == `IOSPM_FC_WRITE_MULTIPLE)
            && (range_out == `IOSPM_RANGE_HOLDING) && slot_ok_out;
        ch_in = (word_in >= `IOSPM_WORD_CH1) && (word_in <= `IOSPM_WORD_CH4);
        ch_out = (word_out >= `IOSPM_WORD_CH1) && (word_out <= `IOSPM_WORD_CH4);
        chan_in = 2'(word_in - `IOSPM_WORD_CH1);
        chan_out = 2'(word_out - `IOSPM_WORD_CH1);
        // one request kind at a time; anything unmatched is refused
        if (is_write_hold) begin
            op = iospm_pkg::IOSPM_WRITE;
        end else if (is_read_in || is_read_hold) begin
            op = iospm_pkg::IOSPM_READ;
        end else begin
            op = iospm_pkg::IOSPM_IDLE;
        end
    end

    // status: flag at bit eight, type in the low byte
    always_comb begin
        in_status = 16'h0000;
        out_status = 16'h0000;
        in_status[`IOSPM_STALE_BIT] = state_reg.temp_stale;
        in_status[`IOSPM_TYPE_MSB:0] = temp_type_valid_i ? TEMP_TYPE_ID : `IOSPM_TYPE_NONE;
        out_status[`IOSPM_STALE_BIT] = state_reg.out_stale;
        out_status[`IOSPM_TYPE_MSB:0] = out_type_valid_i ? OUT_TYPE_ID : `IOSPM_TYPE_NONE;
    end

    // read words; reserved words fall through to zero
    always_comb begin
        in_word = 16'h0000;
        out_word = 16'h0000;
        if (word_in == `IOSPM_WORD_STATUS) begin
            in_word = in_status;
        end else if (ch_in) begin
            in_word = state_reg.temp[chan_in];
        end
        if (word_out == `IOSPM_WORD_STATUS) begin
            out_word = out_status;
        end else if (ch_out) begin
            out_word = state_reg.aout[chan_out];
        end
    end

    always_comb begin
        state_next = state_reg;
        state_next.rsp_valid = 1'b0;
        state_next.rsp_ok = 1'b0;
        // freeze and flag on link loss
        // link loss wins over a pending update so frozen data stays frozen
        if (!temp_link_ok_i) begin
            state_next.temp_stale = 1'b1;
        end else if (temp_update_i) begin
            state_next.temp[0] = temperature_value_one_i;
            state_next.temp[1] = temperature_value_two_i;
            state_next.temp[2] = temperature_value_three_i;
            state_next.temp[3] = temperature_value_four_i;
            state_next.temp_stale = 1'b0;
        end
        if (req_valid_i) begin
            state_next.rsp_valid = 1'b1;
            state_next.rdata = 16'h0000;
            unique case (op)
                iospm_pkg::IOSPM_READ: begin
                    state_next.rsp_ok = 1'b1;
                    if (is_read_in) begin
                        state_next.rdata = in_word;
                    end else begin
                        state_next.rdata = out_word;
                    end
                end
                iospm_pkg::IOSPM_WRITE: begin
                    state_next.rsp_ok = 1'b1;
                    // cleared once, sticky until reset
                    // a write to the status or a reserved word counts as well
                    state_next.out_stale = 1'b0;
                    if (ch_out) begin
                        state_next.aout[chan_out] = req_wdata_i;
                    end
                end
                iospm_pkg::IOSPM_IDLE: begin
                    // refused: ok stays low and data reads zero
                    state_next.rsp_ok = 1'b0;
                end
            endcase
        end
        if (sys_rst_i) begin
            state_next = '0;
            state_next.temp_stale = 1'b1;
            state_next.out_stale = 1'b1;
        end
    end

    // one register stage; reset is folded into the next-state logic
    always_ff @(posedge ref_clk_i) begin
        state_reg <= state_next;
    end

    assign analog_out_value_one_o = state_reg.aout[0];
    assign analog_out_value_two_o = state_reg.aout[1];
    assign analog_out_value_three_o = state_reg.aout[2];
    assign analog_out_value_four_o = state_reg.aout[3];
    assign rsp_valid_o = state_reg.rsp_valid;
    assign rsp_ok_o = state_reg.rsp_ok;
    assign rsp_rdata_o = state_reg.rdata;
endmodule
`default_nettype wire

/* bench/iospm_map_asserts.sv */
// port checker for the slot process map
`timescale 1ns/1ps
`default_nettype none
module iospm_map_asserts (
    // watched ports
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] radio_station_number_i,
    input wire logic [6:0] temp_slot_addr_i,
    input wire logic [6:0] out_slot_addr_i,
    input wire logic req_valid_i,
    input wire logic [7:0] req_func_i,
    input wire logic [16:0] req_reg_i,
    input wire logic [15:0] req_wdata_i,
    input wire logic [15:0] analog_out_value_one_o,
    input wire logic rsp_valid_o,
    input wire logic rsp_ok_o,
    input wire logic [15:0] rsp_rdata_o
);
    logic [16:0] tb_w;
    logic [16:0] ob_w;
    logic me;
    assign tb_w = 17'h07530 + 17'(temp_slot_addr_i) * 17'h0000a;
    assign ob_w = 17'h09c40 + 17'(out_slot_addr_i) * 17'h0000a;
    assign me = req_valid_i && radio_station_number_i == 8'h01;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    rsp_next_a: assert property (req_valid_i |=> rsp_valid_o)
        else $error("no answer");
    rsp_quiet_a: assert property (!req_valid_i |=> !rsp_valid_o)
        else $error("stray answer");
    station_only_a: assert property (req_valid_i && !me |=> !rsp_ok_o)
        else $error("foreign station served");
    range_func_a: assert property (me && req_func_i == 8'h04 && req_reg_i == ob_w |=> !rsp_ok_o)
        else $error("wrong function served");
    out_take_a: assert property (me && req_func_i == 8'h10 && req_reg_i == ob_w + 17'h00002
        |=> analog_out_value_one_o == $past(req_wdata_i))
        else $error("output not taken");
    rsvd_zero_a: assert property (me && req_func_i == 8'h04 && req_reg_i == tb_w + 17'h00001
        |=> rsp_ok_o && rsp_rdata_o == 16'h0000)
        else $error("reserved not zero");
    slot_bound_a: assert property (me && req_reg_i == tb_w + 17'h0000a |=> !rsp_ok_o)
        else $error("outside slot served");
    status_high_a: assert property (me && req_func_i == 8'h03 && req_reg_i == ob_w
        |=> rsp_rdata_o[15:9] == 7'h00)
        else $error("status high bits set");
    reset_clear_a: assert property (disable iff (1'b0) sys_rst_i |=> !rsp_valid_o)
        else $error("answer in reset");
endmodule
bind iospm_map iospm_map_asserts i_chk (.*);
`default_nettype wire

/* bench/iospm_master_model.sv */
// behavioural bus master issuing one-word register requests
`timescale 1ns/1ps
`default_nettype none
module iospm_master_model (
    // clock
    input wire logic ref_clk_i,
    // request
    output logic req_valid_o,
    output logic [7:0] req_func_o,
    output logic [16:0] req_reg_o,
    output logic [15:0] req_wdata_o,
    // answer
    input wire logic rsp_valid_i,
    input wire logic rsp_ok_i,
    input wire logic [15:0] rsp_rdata_i
);
    initial begin
        req_valid_o = 1'b0;
        req_func_o = 8'h00;
        req_reg_o = 17'h00000;
        req_wdata_o = 16'h0000;
    end
    task automatic xfer(input logic [7:0] f, input logic [16:0] r, input logic [15:0] d,
                        output logic [15:0] q, output logic k);
        @(posedge ref_clk_i);
        req_valid_o <= 1'b1;
        req_func_o <= f;
        req_reg_o <= r;
        req_wdata_o <= d;
        @(posedge ref_clk_i);
        req_valid_o <= 1'b0;
        // released data flips so stale values never match
        req_wdata_o <= ~d;
        @(posedge ref_clk_i);
        q = rsp_rdata_i;
        k = rsp_valid_i & rsp_ok_i;
    endtask
endmodule
`default_nettype wire

/* bench/iospm_map_tb.sv */
// self-checking bench for the slot process map
`timescale 1ns/1ps
`default_nettype none
module iospm_map_tb;
    localparam logic [16:0] TB = 17'h075a8;
    localparam logic [16:0] OB = 17'h09e16;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] radio_station_number_i = 8'h01;
    logic [6:0] temp_slot_addr_i = 7'h0c;
    logic [6:0] out_slot_addr_i = 7'h2f;
    logic temp_link_ok_i = 1'b1;
    logic temp_type_valid_i = 1'b0;
    logic temp_update_i = 1'b0;
    logic out_type_valid_i = 1'b1;
    logic [15:0] temperature_value_one_i = 16'h0000;
    logic [15:0] temperature_value_two_i = 16'h0000;
    logic [15:0] temperature_value_three_i = 16'h0000;
    logic [15:0] temperature_value_four_i = 16'h0000;
    logic [15:0] analog_out_value_one_o, analog_out_value_two_o;
    logic [15:0] analog_out_value_three_o, analog_out_value_four_o;
    logic req_valid_i, rsp_valid_o, rsp_ok_o, k;
    logic [7:0] req_func_i;
    logic [16:0] req_reg_i;
    logic [15:0] req_wdata_i, rsp_rdata_o, q;
    int num_errors = 0;
    int total_checks = 0;
    iospm_map i_dut (.*);
    iospm_master_model i_mst (.ref_clk_i(ref_clk_i), .req_valid_o(req_valid_i),
        .req_func_o(req_func_i), .req_reg_o(req_reg_i), .req_wdata_o(req_wdata_i),
        .rsp_valid_i(rsp_valid_o), .rsp_ok_i(rsp_ok_o), .rsp_rdata_i(rsp_rdata_o));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] f, input logic [16:0] r, input logic [15:0] e,
                      input logic eo);
        i_mst.xfer(f, r, 16'h0000, q, k);
        chk(q, e);
        chk({15'h0000, k}, {15'h0000, eo});
    endtask
    task automatic upd(input logic [15:0] b);
        @(posedge ref_clk_i);
        temp_type_valid_i <= 1'b1;
        temp_update_i <= 1'b1;
        temperature_value_one_i <= b;
        temperature_value_two_i <= b + 16'h0001;
        temperature_value_three_i <= b + 16'h0002;
        temperature_value_four_i <= b + 16'h0003;
        @(posedge ref_clk_i);
        temp_update_i <= 1'b0;
    endtask
    task automatic t_temp;
        rd(8'h04, TB, 16'h0100, 1'b1);
        upd(16'h8001);
        for (int i = 0; i < 4; i++) begin
            rd(8'h04, TB + 17'(i + 2), 16'h8001 + 16'(i), 1'b1);
        end
        rd(8'h04, TB, 16'h005a, 1'b1);
        @(posedge ref_clk_i);
        temp_link_ok_i <= 1'b0;
        upd(16'h4000);
        rd(8'h04, TB + 17'h00005, 16'h8004, 1'b1);
        rd(8'h04, TB, 16'h015a, 1'b1);
    endtask
    task automatic t_out;
        rd(8'h03, OB, 16'h016b, 1'b1);
        for (int i = 0; i < 4; i++) begin
            i_mst.xfer(8'h10, OB + 17'(i + 2), 16'hc0d0 + 16'(i), q, k);
            chk({15'h0000, k}, 16'h0001);
        end
        chk(analog_out_value_one_o, 16'hc0d0);
        chk(analog_out_value_two_o, 16'hc0d1);
        chk(analog_out_value_three_o, 16'hc0d2);
        chk(analog_out_value_four_o, 16'hc0d3);
        rd(8'h03, OB + 17'h00003, 16'hc0d1, 1'b1);
        rd(8'h03, OB, 16'h006b, 1'b1);
    endtask
    task automatic t_refuse;
        i_mst.xfer(8'h10, OB + 17'h00007, 16'hffff, q, k);
        rd(8'h03, OB + 17'h00007, 16'h0000, 1'b1);
        rd(8'h04, TB + 17'h00001, 16'h0000, 1'b1);
        rd(8'h04, TB + 17'h0000a, 16'h0000, 1'b0);
        rd(8'h04, OB + 17'h00002, 16'h0000, 1'b0);
        @(posedge ref_clk_i);
        radio_station_number_i <= 8'h02;
        rd(8'h04, TB, 16'h0000, 1'b0);
        @(posedge ref_clk_i);
        radio_station_number_i <= 8'h01;
        rd(8'h03, OB, 16'h006b, 1'b1);
    endtask
    task automatic t_reset;
        @(posedge ref_clk_i);
        sys_rst_i <= 1'b1;
        out_type_valid_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        chk(analog_out_value_two_o, 16'h0000);
        rd(8'h03, OB, 16'h0100, 1'b1);
        rd(8'h03, OB + 17'h00002, 16'h0000, 1'b1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (16) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        t_temp();
        t_out();
        t_refuse();
        t_reset();
        report_and_stop();
    end
    // whole run is about a hundred cycles
    initial begin
        #20000;
        num_errors++;
        report_and_stop();
    end
endmodule
`default_nettype wire
